// ### aie_consts.svh
// Purpose: Named constants for the arithmetic instruction execution unit
// Assumes: Included by every design file that needs figures (BCD unit, execution unit), not by the package
// Notes:   Cycle and byte counts per instruction form, reset values, BCD figures
`ifndef AIE_CONSTS_SVH
`define AIE_CONSTS_SVH

// Encoded lengths in bytes
`define AIE_LEN_ONE        2'h1
`define AIE_LEN_TWO        2'h2

// Execution cycles per form
`define AIE_CYC_ONE        4'h1
`define AIE_CYC_TWO        4'h2
`define AIE_CYC_THREE      4'h3
`define AIE_CYC_DIVIDE     4'h6

// Reset values of the architectural state
`define AIE_ACC_RST        8'h00
`define AIE_AUX_RST        8'h00
`define AIE_PTR_RST        16'h0000
`define AIE_FLAG_RST       1'b0

// Decimal correction figures
`define AIE_BCD_LIMIT      4'h9
`define AIE_BCD_FIX_LO     8'h06
`define AIE_BCD_FIX_HI     8'h60

`endif

// ### aie_pkg.sv
// Purpose: Types shared by the arithmetic execution unit and its helpers
// Assumes: aie_consts.svh holds the figures
// Notes:   Only types live here
package aie_pkg;
  // Arithmetic operation selected by the decoder
  typedef enum logic [3:0] {
    ADD_OP                    = 4'h0,
    SUM_WITH_CARRY_OP         = 4'h1,
    DIFFERENCE_WITH_BORROW_OP = 4'h2,
    PLUS_ONE_OP               = 4'h3,
    MINUS_ONE_OP              = 4'h4,
    PTR_PLUS_ONE_OP           = 4'h5,
    PRODUCT_OP                = 4'h6,
    QUOTIENT_OP               = 4'h7,
    BCD_CORRECT_OP            = 4'h8
  } aie_op_e;

  // Where the operand comes from
  typedef enum logic [2:0] {
    SRC_ACC                = 3'h0,
    SRC_WORK_REGISTER      = 3'h1,
    SRC_DIRECT             = 3'h2,
    SRC_INDIRECT_INDEX_REG = 3'h3,
    SRC_IMMEDIATE          = 3'h4
  } aie_src_e;

  // Sequencer state
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } aie_state_e;
endpackage : aie_pkg

// ### aie_alu_if.sv
// Purpose: Carries operands to the helper units and their results back
// Assumes: One clock; helpers are purely combinational
// Notes:   Main end drives operands, helpers drive results
`timescale 1ns/10ps
interface aie_alu_if;
  logic [7:0]  acc;      // Accumulator operand
  logic [7:0]  aux;      // Auxiliary operand
  logic        cy;       // Carry flag in
  logic        ac;       // Auxiliary carry in
  logic [15:0] prod;     // Full product
  logic [7:0]  quot;     // Quotient
  logic [7:0]  rem;      // Remainder
  logic        dzero;    // Divisor is zero
  logic [7:0]  bcd;      // Corrected value
  logic        bcd_cy;   // Carry after correction

  modport main (output acc, aux, cy, ac, input prod, quot, rem, dzero, bcd, bcd_cy);
  modport md   (input acc, aux, output prod, quot, rem, dzero);
  modport bcdu (input acc, cy, ac, output bcd, bcd_cy);
endinterface : aie_alu_if

// ### aie_muldiv.sv
// Purpose: Product and quotient of accumulator and auxiliary operands
// Assumes: Operands hold still while the sequencer runs
// Notes:   Combinational; the sequencer spends the documented cycles
`timescale 1ns/10ps
module aie_muldiv
  import aie_pkg::*;
(
  aie_alu_if.md u
);
  // Product is always 16 bits wide so nothing is lost
  assign u.prod  = 16'(u.acc) * 16'(u.aux);
  // Zero divisor flagged; quotient and remainder forced to a safe value
  assign u.dzero = (u.aux == 8'h00);
  assign u.quot  = u.dzero ? 8'h00 : (u.acc / u.aux);
  assign u.rem   = u.dzero ? 8'h00 : (u.acc % u.aux);
endmodule : aie_muldiv

// ### aie_bcd.sv
// Purpose: Corrects a binary sum of two packed BCD bytes
// Assumes: Flags are those left by the preceding addition
// Notes:   Carry out may only be set, never cleared
`timescale 1ns/10ps
`include "aie_consts.svh"
module aie_bcd
  import aie_pkg::*;
(
  aie_alu_if.bcdu u
);
  logic [8:0] step_lo;   // After low digit fix
  logic [8:0] step_hi;   // After high digit fix

  // Two-step correction, low digit first
  always_comb
  begin
    step_lo = {1'b0, u.acc};
    if ((u.acc[3:0] > `AIE_BCD_LIMIT) || u.ac)
    begin
      step_lo = 9'(u.acc) + 9'(`AIE_BCD_FIX_LO);
    end
    step_hi = step_lo;
    if ((step_lo[7:4] > `AIE_BCD_LIMIT) || u.cy || step_lo[8])
    begin
      step_hi = 9'(step_lo[7:0]) + 9'(`AIE_BCD_FIX_HI);
      step_hi[8] = 1'b1;
    end
  end

  assign u.bcd    = step_hi[7:0];
  assign u.bcd_cy = step_hi[8] | u.cy;
endmodule : aie_bcd

// ### aie_exec.sv
// Purpose: Executes the arithmetic instruction group of an 8-bit accumulator core
// Assumes: Decoder supplies operation, source and fetched operand with start_in
// Notes:   Holds accumulator, auxiliary, data pointer and arithmetic flags
`timescale 1ns/10ps
`include "aie_consts.svh"
module aie_exec
  import aie_pkg::*;
#(
  parameter int CYC_W = 4                      // Cycle counter width
)
(
  input  wire logic        clk_in,             // Core clock, 100 MHz
  input  wire logic        rst_in,             // Synchronous reset, active high
  input  wire logic        start_in,           // Start one instruction
  input  wire aie_op_e     op_in,              // Operation
  input  wire aie_src_e    src_in,             // Operand source
  input  wire logic [7:0]  opnd_in,            // Fetched operand value
  input  wire logic        acc_wr_in,          // Load accumulator while idle
  input  wire logic        aux_wr_in,          // Load auxiliary while idle
  input  wire logic        cy_wr_in,           // Load carry while idle
  input  wire logic [7:0]  wr_data_in,         // Load value
  output logic             busy_out,           // Instruction running
  output logic             done_out,           // Completion pulse
  output logic             err_out,            // Illegal combination pulse
  output logic [1:0]       len_out,            // Encoded length in bytes
  output logic             wb_valid_out,       // Write-back pulse
  output aie_src_e         wb_src_out,         // Write-back target
  output logic [7:0]       wb_data_out,        // Write-back byte
  output logic [7:0]       acc_out,            // Accumulator
  output logic [7:0]       aux_out,            // Auxiliary register
  output logic [15:0]      ptr_out,            // 16-bit data pointer
  output logic             cy_out,             // Carry flag
  output logic             ac_out,             // Auxiliary carry flag
  output logic             ov_out              // Overflow flag
);

  // Counter must hold the longest run
  if (CYC_W < 3)
  begin : g_chk
    $error("CYC_W too small for the longest instruction");
  end

  aie_alu_if u ();                             // Link to helper units

  aie_muldiv u_md (.u(u.md));
  aie_bcd    u_bcd (.u(u.bcdu));

  assign u.acc = acc_out;
  assign u.aux = aux_out;
  assign u.cy  = cy_out;
  assign u.ac  = ac_out;

  aie_state_e       state;                     // Sequencer state
  aie_state_e       next_state;
  logic [CYC_W-1:0] cnt;                       // Cycles left
  logic [CYC_W-1:0] next_cnt;
  aie_op_e          op_q;                      // Latched operation
  aie_op_e          next_op_q;
  aie_src_e         src_q;                     // Latched source
  aie_src_e         next_src_q;
  logic [7:0]       opnd_q;                    // Latched operand
  logic [7:0]       next_opnd_q;
  logic             next_busy, next_done, next_err, next_wb_valid;
  logic [1:0]       next_len;
  aie_src_e         next_wb_src;
  logic [7:0]       next_wb_data, next_acc, next_aux;
  logic [15:0]      next_ptr;
  logic             next_cy, next_ac, next_ov;

  // Decode of the incoming request
  logic             legal;                     // Combination exists
  logic [CYC_W-1:0] req_cyc;                   // Cycles for it
  logic [1:0]       req_len;                   // Bytes for it

  // Length and cycle table per form
  always_comb
  begin
    legal   = 1'b1;
    req_cyc = CYC_W'(`AIE_CYC_ONE);
    req_len = `AIE_LEN_ONE;
    case (op_in)
      ADD_OP, SUM_WITH_CARRY_OP, DIFFERENCE_WITH_BORROW_OP:
      begin
        // Register form 1/1, indirect 1/2, direct and immediate 2/2
        if (src_in == SRC_WORK_REGISTER)
        begin
          req_cyc = CYC_W'(`AIE_CYC_ONE);
        end
        else if (src_in == SRC_INDIRECT_INDEX_REG)
        begin
          req_cyc = CYC_W'(`AIE_CYC_TWO);
        end
        else if ((src_in == SRC_DIRECT) || (src_in == SRC_IMMEDIATE))
        begin
          req_cyc = CYC_W'(`AIE_CYC_TWO);
          req_len = `AIE_LEN_TWO;
        end
        else
        begin
          legal = 1'b0;                        // No accumulator-to-itself form
        end
      end
      PLUS_ONE_OP, MINUS_ONE_OP:
      begin
        // Any source may be the target, immediate cannot
        if (src_in == SRC_ACC)
        begin
          req_cyc = CYC_W'(`AIE_CYC_ONE);
        end
        else if (src_in == SRC_WORK_REGISTER)
        begin
          req_cyc = CYC_W'(`AIE_CYC_TWO);
        end
        else if (src_in == SRC_DIRECT)
        begin
          req_cyc = CYC_W'(`AIE_CYC_THREE);
          req_len = `AIE_LEN_TWO;
        end
        else if (src_in == SRC_INDIRECT_INDEX_REG)
        begin
          req_cyc = CYC_W'(`AIE_CYC_THREE);
        end
        else
        begin
          legal = 1'b0;
        end
      end
      PTR_PLUS_ONE_OP: req_cyc = CYC_W'(`AIE_CYC_ONE);
      PRODUCT_OP:      req_cyc = CYC_W'(`AIE_CYC_TWO);
      QUOTIENT_OP:     req_cyc = CYC_W'(`AIE_CYC_DIVIDE);
      BCD_CORRECT_OP:  req_cyc = CYC_W'(`AIE_CYC_THREE);
      default:         legal   = 1'b0;
    endcase
  end

  // Adder and subtractor with flag terms
  logic       cin;                             // Carry or borrow in
  logic [8:0] full;                            // Nine-bit result
  logic [4:0] low;                             // Low digit result
  logic [7:0] mid;                             // Eight-bit result of the low seven bits, for bit 6 carry
  always_comb
  begin
    cin = (op_q == ADD_OP) ? 1'b0 : cy_out;
    if (op_q == DIFFERENCE_WITH_BORROW_OP)
    begin
      full = 9'(acc_out) - 9'(opnd_q) - 9'(cin);
      low  = 5'(acc_out[3:0]) - 5'(opnd_q[3:0]) - 5'(cin);
      mid  = 8'(acc_out[6:0]) - 8'(opnd_q[6:0]) - 8'(cin);
    end
    else
    begin
      full = 9'(acc_out) + 9'(opnd_q) + 9'(cin);
      low  = 5'(acc_out[3:0]) + 5'(opnd_q[3:0]) + 5'(cin);
      mid  = 8'(acc_out[6:0]) + 8'(opnd_q[6:0]) + 8'(cin);
    end
  end

  // Sequencer and commit of results
  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_op_q     = op_q;
    next_src_q    = src_q;
    next_opnd_q   = opnd_q;
    next_busy     = busy_out;
    next_done     = 1'b0;
    next_err      = 1'b0;
    next_wb_valid = 1'b0;
    next_len      = len_out;
    next_wb_src   = wb_src_out;
    next_wb_data  = wb_data_out;
    next_acc      = acc_out;
    next_aux      = aux_out;
    next_ptr      = ptr_out;
    next_cy       = cy_out;
    next_ac       = ac_out;
    next_ov       = ov_out;
    case (state)
      ST_IDLE:
      begin
        // Side loads only while idle, so operands stay put during a run
        if (acc_wr_in) next_acc = wr_data_in;
        if (aux_wr_in) next_aux = wr_data_in;
        if (cy_wr_in)  next_cy  = wr_data_in[0];
        if (start_in && legal)
        begin
          next_state  = ST_RUN;
          next_cnt    = req_cyc;
          next_op_q   = op_in;
          next_src_q  = src_in;
          next_opnd_q = (src_in == SRC_ACC) ? acc_out : opnd_in;
          next_len    = req_len;
          next_busy   = 1'b1;
        end
        else if (start_in)
        begin
          next_err = 1'b1;                     // Unknown form refused
        end
      end
      ST_RUN:
      begin
        next_cnt = cnt - CYC_W'(1);
        if (cnt == CYC_W'(`AIE_CYC_ONE))
        begin
          next_state = ST_IDLE;
          next_busy  = 1'b0;
          next_done  = 1'b1;
          case (op_q)
            ADD_OP, SUM_WITH_CARRY_OP, DIFFERENCE_WITH_BORROW_OP:
            begin
              next_acc = full[7:0];
              next_cy  = full[8];
              next_ac  = low[4];
              next_ov  = full[8] ^ mid[7];
            end
            PLUS_ONE_OP, MINUS_ONE_OP:
            begin
              // Flags untouched; non-accumulator targets go back out
              next_wb_data = (op_q == PLUS_ONE_OP) ? opnd_q + 8'h01
                                                   : opnd_q - 8'h01;
              if (src_q == SRC_ACC)
              begin
                next_acc = next_wb_data;
              end
              else
              begin
                next_wb_valid = 1'b1;
                next_wb_src   = src_q;
              end
            end
            PTR_PLUS_ONE_OP: next_ptr = ptr_out + 16'h0001;
            PRODUCT_OP:
            begin
              next_acc = u.prod[7:0];
              next_aux = u.prod[15:8];
              next_cy  = 1'b0;
              next_ov  = (u.prod[15:8] != 8'h00);
            end
            QUOTIENT_OP:
            begin
              // Zero divisor keeps both registers and raises overflow
              next_cy = 1'b0;
              next_ov = u.dzero;
              if (!u.dzero)
              begin
                next_acc = u.quot;
                next_aux = u.rem;
              end
            end
            BCD_CORRECT_OP:
            begin
              next_acc = u.bcd;
              next_cy  = u.bcd_cy;
            end
            default: next_err = 1'b1;
          endcase
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State registers; all outputs straight from here
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state        <= ST_IDLE;
      cnt          <= '0;
      op_q         <= ADD_OP;
      src_q        <= SRC_ACC;
      opnd_q       <= 8'h00;
      busy_out     <= 1'b0;
      done_out     <= 1'b0;
      err_out      <= 1'b0;
      len_out      <= `AIE_LEN_ONE;
      wb_valid_out <= 1'b0;
      wb_src_out   <= SRC_ACC;
      wb_data_out  <= 8'h00;
      acc_out      <= `AIE_ACC_RST;
      aux_out      <= `AIE_AUX_RST;
      ptr_out      <= `AIE_PTR_RST;
      cy_out       <= `AIE_FLAG_RST;
      ac_out       <= `AIE_FLAG_RST;
      ov_out       <= `AIE_FLAG_RST;
    end
    else
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      op_q         <= next_op_q;
      src_q        <= next_src_q;
      opnd_q       <= next_opnd_q;
      busy_out     <= next_busy;
      done_out     <= next_done;
      err_out      <= next_err;
      len_out      <= next_len;
      wb_valid_out <= next_wb_valid;
      wb_src_out   <= next_wb_src;
      wb_data_out  <= next_wb_data;
      acc_out      <= next_acc;
      aux_out      <= next_aux;
      ptr_out      <= next_ptr;
      cy_out       <= next_cy;
      ac_out       <= next_ac;
      ov_out       <= next_ov;
    end
  end

  // Helper: busy edges since the accepted start, and the expected length
  // Starts at zero so the count equals the table figure at the completion pulse
  logic             take;                      // Request accepted
  logic [CYC_W-1:0] run_len;
  logic [CYC_W-1:0] exp_len;
  assign take = (state == ST_IDLE) && start_in && legal;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      run_len <= '0;
      exp_len <= '0;
    end
    else if (take)
    begin
      run_len <= CYC_W'(0);
      exp_len <= req_cyc;
    end
    else if (busy_out)
    begin
      run_len <= run_len + CYC_W'(1);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_done_timing:  assert property (done_out |-> run_len == exp_len)
    else $error("completion not at the table cycle count");
  a_add_reg_one:  assert property (take && op_in == ADD_OP && src_in == SRC_WORK_REGISTER
                                   |-> ##2 done_out)
    else $error("register add not done in one cycle");
  a_add_dir_len:  assert property (take && src_in == SRC_DIRECT |=> len_out == 2'h2 [*2])
    else $error("direct form length not two bytes");
  a_ind_len_one:  assert property (take && src_in == SRC_INDIRECT_INDEX_REG
                                   |=> len_out == 2'h1)
    else $error("indirect form length not one byte");
  a_inc_dir_three: assert property (take && op_in == PLUS_ONE_OP && src_in == SRC_DIRECT
                                   |=> !done_out [*3] ##1
                                       (done_out && wb_valid_out))
    else $error("direct increment not written back at cycle three");
  a_quot_six:     assert property (take && op_in == QUOTIENT_OP |-> ##7 done_out)
    else $error("divide not done in six cycles");
  a_prod_value:   assert property (done_out && op_q == PRODUCT_OP
                                   |-> {aux_out, acc_out} == 16'($past(acc_out)) *
                                       16'($past(aux_out)))
    else $error("product split wrong");
  a_div_zero_ov:  assert property (done_out && op_q == QUOTIENT_OP && $past(aux_out) == 8'h00
                                   |-> ov_out && $stable(acc_out))
    else $error("zero divisor not flagged");
  a_step_flags:   assert property (done_out && (op_q == PLUS_ONE_OP || op_q == MINUS_ONE_OP)
                                   |-> $stable(cy_out) && $stable(ac_out) && $stable(ov_out))
    else $error("plus or minus one changed flags");
  a_ptr_step:     assert property (done_out && op_q == PTR_PLUS_ONE_OP
                                   |-> ptr_out == $past(ptr_out) + 16'h0001)
    else $error("data pointer not advanced");
  a_bcd_three:    assert property (take && op_in == BCD_CORRECT_OP |-> ##4 done_out)
    else $error("BCD correction not done in three cycles");

  c_sub_borrow:   cover property (done_out && op_q == DIFFERENCE_WITH_BORROW_OP && cy_out);
  c_div_run:      cover property (done_out && op_q == QUOTIENT_OP && !ov_out);
  c_ind_wb:       cover property (wb_valid_out && wb_src_out == SRC_INDIRECT_INDEX_REG);
  c_refused:      cover property (err_out);
endmodule : aie_exec

// ### aie_exec_tb.sv
// Purpose: Self-checking bench for the arithmetic execution unit
// Assumes: Results land with the completion pulse; side loads only while idle
// Notes:   Driver notes each expectation in a queue; a monitor checks on done
`timescale 1ns/10ps
module aie_exec_tb;
  import aie_pkg::*;
  // Expected architectural state after one instruction
  typedef struct {
    logic [7:0]  acc, aux, wbd;
    logic        cy, ac, ov, wbv;
    logic [15:0] ptr;
    aie_src_e    wbs;
    logic [1:0]  len;
    int          cyc;
  } aie_exp_s;

  logic        clk_in, rst_in, start_in, acc_wr_in, aux_wr_in, cy_wr_in;
  aie_op_e     op_in;
  aie_src_e    src_in;
  logic [7:0]  opnd_in, wr_data_in;
  logic        busy_out, done_out, err_out, wb_valid_out, cy_out, ac_out, ov_out;
  logic [1:0]  len_out;
  aie_src_e    wb_src_out;
  logic [7:0]  wb_data_out, acc_out, aux_out;
  logic [15:0] ptr_out;
  aie_exp_s    m;           // Reference state
  aie_exp_s    exp_q[$];    // Pending expectations, oldest first
  aie_exp_s    e;           // Note under check
  int          err_count, n_tests, cyc, seed;

  aie_exec i_aie_exec (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in), .op_in(op_in),
    .src_in(src_in), .opnd_in(opnd_in), .acc_wr_in(acc_wr_in), .aux_wr_in(aux_wr_in),
    .cy_wr_in(cy_wr_in), .wr_data_in(wr_data_in), .busy_out(busy_out), .done_out(done_out),
    .err_out(err_out), .len_out(len_out), .wb_valid_out(wb_valid_out),
    .wb_src_out(wb_src_out), .wb_data_out(wb_data_out), .acc_out(acc_out),
    .aux_out(aux_out), .ptr_out(ptr_out), .cy_out(cy_out), .ac_out(ac_out), .ov_out(ov_out));

  // 100 MHz core clock
  always #5 clk_in = ~clk_in;

  // Verdict and end of run; the only place the run stops
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // One comparison; case inequality so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      err_count++;
      $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, want);
    end
  endtask : chk

  // Side load of acc (0), aux (1) or carry (2) on an idle edge
  task automatic load(input int k, input logic [7:0] d);
    // Only the chosen strobe is touched, so back-to-back loads never rewrite one
    if (k == 0) acc_wr_in = 1'b1;
    else if (k == 1) aux_wr_in = 1'b1;
    else cy_wr_in = 1'b1;
    wr_data_in = d;
    if (k == 0) m.acc = d;
    else if (k == 1) m.aux = d;
    else m.cy = d[0];
    @(negedge clk_in);
    if (k == 0) acc_wr_in = 1'b0;
    else if (k == 1) aux_wr_in = 1'b0;
    else cy_wr_in = 1'b0;
  endtask : load

  // Illegal combination: one error pulse, nothing started
  task automatic refuse(input aie_op_e op, input aie_src_e src);
    op_in    = op;
    src_in   = src;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    chk({err_out, busy_out, done_out}, 3'h4);
    // Let an edge pass so the next request does not rewrite start in this step
    @(negedge clk_in);
  endtask : refuse

  // Works out the expected result, then runs one instruction to completion
  task automatic issue(input aie_op_e op, input aie_src_e src, input logic [7:0] v);
    logic [8:0] s;
    logic       c;
    int         n;
    int         w;
    c     = (op == ADD_OP) ? 1'b0 : m.cy;
    n     = (src == SRC_WORK_REGISTER) ? 1 : 2;
    m.wbv = 1'b0;
    m.len = (src == SRC_DIRECT || src == SRC_IMMEDIATE) ? 2'h2 : 2'h1;
    case (op)
      ADD_OP, SUM_WITH_CARRY_OP:
      begin
        s     = m.acc + v + c;
        m.ac  = ({1'b0, m.acc[3:0]} + v[3:0] + c) > 5'h0F;
        m.ov  = s[8] ^ ((m.acc[6:0] + v[6:0] + c) > 8'h7F);
        m.cy  = s[8];
        m.acc = s[7:0];
      end
      DIFFERENCE_WITH_BORROW_OP:
      begin
        s     = {1'b0, m.acc} - v - c;
        m.ac  = {1'b0, m.acc[3:0]} < (v[3:0] + c);
        m.ov  = s[8] ^ ({1'b0, m.acc[6:0]} < (v[6:0] + c));
        m.cy  = s[8];
        m.acc = s[7:0];
      end
      PLUS_ONE_OP, MINUS_ONE_OP:
      begin
        // Flags stay put; only the target changes
        s = (op == PLUS_ONE_OP) ? 9'h001 : 9'h1FF;
        n = (src == SRC_ACC) ? 1 : (src == SRC_WORK_REGISTER) ? 2 : 3;
        // The accumulator target refreshes the write-back byte too, without a pulse
        m.wbd = ((src == SRC_ACC) ? m.acc : v) + s[7:0];
        if (src == SRC_ACC)
          m.acc = m.wbd;
        else
        begin
          m.wbv = 1'b1;
          m.wbs = src;
        end
      end
      PTR_PLUS_ONE_OP:
      begin
        n     = 1;
        m.ptr = m.ptr + 16'h0001;
      end
      PRODUCT_OP:
      begin
        {m.aux, m.acc} = m.acc * m.aux;
        m.cy = 1'b0;
        m.ov = |m.aux;
      end
      QUOTIENT_OP:
      begin
        // Zero divisor leaves both registers alone
        n    = 6;
        m.cy = 1'b0;
        m.ov = (m.aux == 8'h00);
        if (!m.ov) {m.acc, m.aux} = {m.acc / m.aux, m.acc % m.aux};
      end
      default:
      begin
        n = 3;
        s = {1'b0, m.acc};
        if (s[3:0] > 4'h9 || m.ac) s = s + 9'h006;
        c = m.cy | s[8];
        if (s[7:4] > 4'h9 || c) s = {1'b0, s[7:0]} + 9'h060;
        m.cy  = c | s[8];
        m.acc = s[7:0];
      end
    endcase
    m.cyc = cyc + 1 + n;
    exp_q.push_back(m);
    op_in    = op;
    src_in   = src;
    opnd_in  = v;
    start_in = 1'b1;
    @(negedge clk_in);
    // A request made while busy must be ignored
    start_in = (n > 2);
    op_in    = PLUS_ONE_OP;
    src_in   = SRC_ACC;
    w        = 0;
    while (done_out !== 1'b1 && w < 10)
    begin
      chk(busy_out, 1'b1);
      @(negedge clk_in);
      if (w == 0 && n > 2) start_in = 1'b0;
      w++;
    end
  endtask : issue

  // Monitor: each completion pulse takes the oldest note
  always @(negedge clk_in)
  begin
    if (!rst_in && done_out === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0);
      else
      begin
        e = exp_q.pop_front();
        chk(cyc, e.cyc);
        chk({acc_out, aux_out, cy_out, ac_out, ov_out}, {e.acc, e.aux, e.cy, e.ac, e.ov});
        chk({ptr_out, len_out}, {e.ptr, e.len});
        chk({wb_valid_out, wb_src_out, wb_data_out}, {e.wbv, e.wbs, e.wbd});
      end
    end
  end

  // Cycle count and hang guard
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc > 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  // Main sequence: every legal operation and source, four rounds
  initial
  begin
    {clk_in, start_in, acc_wr_in, aux_wr_in, cy_wr_in, opnd_in, wr_data_in} = '0;
    op_in  = ADD_OP;
    src_in = SRC_ACC;
    rst_in = 1'b1;
    {err_count, n_tests, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd90972};
    m = '{acc: 8'h00, aux: 8'h00, wbd: 8'h00, cy: 1'b0, ac: 1'b0, ov: 1'b0, wbv: 1'b0,
          ptr: 16'h0000, wbs: SRC_ACC, len: 2'h1, cyc: 0};
    repeat (12) @(negedge clk_in);
    chk({acc_out, aux_out, cy_out, ac_out, ov_out}, 19'h0);
    chk({ptr_out, len_out, wb_src_out, busy_out, done_out, err_out}, {16'h0, 2'h1, SRC_ACC, 3'h0});
    rst_in = 1'b0;
    for (int r = 0; r < 4; r++)
      for (int o = 0; o < 9; o++)
        for (int s = 0; s < 5; s++)
        begin
          // Skip the refused pairs and sources the op ignores
          if ((o < 3 && s == 0) || (o > 4 && s != 0) || (o > 2 && o < 5 && s == 4)) continue;
          if (s == 1 || o == 7)
          begin
            load(0, (r == 1) ? 8'hFF : 8'($random(seed)));
            load(1, (r == 0 && o == 7) ? 8'h00 : 8'($random(seed)));
            load(2, 8'($random(seed)));
          end
          issue(aie_op_e'(o), aie_src_e'(s), (r == 1) ? 8'hFF : 8'($random(seed)));
        end
    refuse(ADD_OP, SRC_ACC);
    refuse(MINUS_ONE_OP, SRC_IMMEDIATE);
    issue(SUM_WITH_CARRY_OP, SRC_IMMEDIATE, 8'h5A);
    repeat (3) @(negedge clk_in);
    chk(exp_q.size(), 32'h0);
    end_sim();
  end
endmodule : aie_exec_tb
